// ### pkg/mct_pkg.sv
// Contract
// - Sleep timer takes 1 to 255 seconds; zero disables and powersaves it.
// - Writing the timer starts timing; expiry sets the timer flag, interrupt if enabled.
// - Timer is one-shot and restarts only when the timer register is rewritten.
// - Fast-lock high selects fast peak detection and wide loop bandwidth.
// - Fast-lock low selects averaging detection, medium bandwidth 30 bits, then narrow.
// - Hold at one freezes the bit-sync phase; zero follows normal acquisition.
// - Hold is ignored whenever fast-lock is high.
// - Control bit 5 powersaves the receiver when one, enables it when zero.
// - Control bit 4 powersaves transmitter; clearing starts, setting stops transmission at once.
// - First block after continuity rises is preceded by dotting and sync word.
// - Three-bit limit bounds sync word errors; accepted match sets flag, loads count.
// - Accepted sync loads received symbols, updates syndrome and may interrupt.
// - Mask bits 7 to 3 pass their interrupts to the pin when one.
// - Mask only gates the pin and never alters the flag or status contents.
// - Gate bit 2 at zero suppresses sync, decode, idle interrupts on errored data.
// - Timer flag sets on expiry and clears when the flag register is read.
// - Sync error count is a 3-bit status field updated on each accepted sync.
package mct_pkg;

  localparam logic [6:0] MCT_ADDR_TIMER   = 7'h2F;
  localparam logic [6:0] MCT_ADDR_CONTROL = 7'h30;
  localparam logic [6:0] MCT_ADDR_MASK    = 7'h31;
  localparam logic [6:0] MCT_ADDR_FLAGS   = 7'h50;

  localparam int MCT_CTL_FAST_LOCK = 7;
  localparam int MCT_CTL_HOLD      = 6;
  localparam int MCT_CTL_RX_PS     = 5;
  localparam int MCT_CTL_TX_PS     = 4;
  localparam int MCT_CTL_CI        = 3;
  localparam int MCT_CTL_SYNC_WORD_ERROR_LIMIT_MSB  = 2;
  localparam int MCT_CTL_SYNC_WORD_ERROR_LIMIT_LSB  = 0;

  localparam int MCT_MSK_SRC_MSB   = 7;
  localparam int MCT_MSK_SRC_LSB   = 3;
  localparam int MCT_MSK_ERR_GATE  = 2;

  localparam int MCT_FLG_SYNC      = 4;
  localparam int MCT_FLG_DEC       = 3;
  localparam int MCT_FLG_IDLE      = 2;
  localparam int MCT_FLG_TX        = 1;
  localparam int MCT_FLG_TIMER     = 0;
  localparam int MCT_NUM_FLAGS     = 5;
  localparam int MCT_FLAG_POS_LSB  = 3;

  localparam logic [7:0] MCT_CONTROL_RST = 8'h30;
  localparam logic [7:0] MCT_MASK_RST    = 8'h00;
  localparam logic [7:0] MCT_TIMER_RST   = 8'h00;
  localparam logic [2:0] MCT_ERR_RST     = 3'h0;
  localparam logic [2:0] MCT_RX_GATED    = 3'h7;

  localparam int MCT_CLK_PERIOD_NS  = 25;
  localparam int MCT_SECOND_NS      = 1000000000;
  localparam int MCT_SECOND_CYCLES  = MCT_SECOND_NS / MCT_CLK_PERIOD_NS;
  localparam int MCT_MEDIUM_BW_BITS = 30;

  typedef enum logic [1:0] {
    MCT_BW_WIDE   = 2'h0,
    MCT_BW_MEDIUM = 2'h1,
    MCT_BW_NARROW = 2'h3
  } mct_bw_e;

endpackage

// ### hdl/mct_sleep_timer.sv
`timescale 1ns/1ps
module mct_sleep_timer
  import mct_pkg::*;
#(
  parameter int SECOND_CYCLES = MCT_SECOND_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       load,
  input  wire logic [7:0] load_seconds,
  output logic            expired,
  output logic            powersave
);

  localparam int PW = $clog2(SECOND_CYCLES);
  localparam logic [PW-1:0] PRE_LAST = PW'(SECOND_CYCLES - 1);

  typedef struct packed {
    logic [PW-1:0] prescale;
    logic [7:0]    seconds;
    logic          running;
    logic          expired;
    logic          powersave;
  } mct_tmr_s;

  mct_tmr_s st_reg;
  mct_tmr_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.expired = 1'b0;
    if (load) begin
      st_next.seconds   = load_seconds;
      st_next.prescale  = '0;
      st_next.running   = (load_seconds != MCT_TIMER_RST);
      st_next.powersave = (load_seconds == MCT_TIMER_RST);
    end else if (st_reg.running) begin
      if (st_reg.prescale == PRE_LAST) begin
        st_next.prescale = '0;
        st_next.seconds  = st_reg.seconds - 8'h01;
        if (st_reg.seconds == 8'h01) begin
          st_next.running = 1'b0;
          st_next.expired = 1'b1;
        end
      end else begin
        st_next.prescale = st_reg.prescale + PW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= '{prescale: '0, seconds: MCT_TIMER_RST, running: 1'b0,
                  expired: 1'b0, powersave: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired   = st_reg.expired;
  assign powersave = st_reg.powersave;

endmodule

// ### hdl/mct_control_top.sv
`timescale 1ns/1ps
module mct_control_top
  import mct_pkg::*;
#(
  parameter int SECOND_CYCLES = MCT_SECOND_CYCLES,
  parameter int MEDIUM_BITS   = MCT_MEDIUM_BW_BITS
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       bus_cs_n,
  input  wire logic       bus_rd_n,
  input  wire logic       bus_wr_n,
  input  wire logic [6:0] bus_addr,
  input  wire logic [7:0] bus_data_in,
  output logic      [7:0] bus_data_out,
  output logic            bus_data_oe,
  input  wire logic       bit_tick,
  input  wire logic       sync_candidate,
  input  wire logic [2:0] sync_candidate_errors,
  input  wire logic       sync_lost,
  input  wire logic       decode_change,
  input  wire logic       idle_change,
  input  wire logic       tx_buffer_empty,
  input  wire logic       tx_block_start,
  input  wire logic       errored_data,
  output logic            interrupt_request_pin_n,
  output logic            receiver_powersave,
  output logic            transmitter_powersave,
  output logic            continuity_indicator,
  output logic            fast_peak_detect,
  output logic [1:0]      loop_bandwidth,
  output logic            phase_freeze,
  output logic            preamble_pending,
  output logic            rx_load,
  output logic [2:0]      sync_error_count,
  output logic            timer_powersave
);

  localparam int CW = $clog2(MEDIUM_BITS + 1);
  localparam logic [CW-1:0] MED_LAST = CW'(MEDIUM_BITS - 1);

  // One sample of the host bus pins, kept together through the synchroniser.
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [6:0] addr;
    logic [7:0] data;
  } mct_pins_s;

  typedef struct packed {
    mct_pins_s     pins_s1;
    mct_pins_s     pins_s2;
    logic          wr_act_d;
    logic          rd_act_d;
    logic [6:0]    acc_addr;
    logic [7:0]    acc_data;
    logic [7:0]    control;
    logic [7:0]    mask;
    logic [MCT_NUM_FLAGS-1:0] flags;
    logic [2:0]    sync_errs;
    logic          rx_load;
    mct_bw_e       bw;
    logic [CW-1:0] bw_cnt;
    logic          ci_d;
    logic          preamble;
    logic          freeze;
    logic          irq_n;
    logic [7:0]    dout;
    logic          doe;
  } mct_top_s;

  mct_top_s st_reg;
  mct_top_s st_next;

  logic                     timer_expired;
  logic                     timer_ps;
  logic                     timer_load;
  logic                     cs_n_s;
  logic                     rd_n_s;
  logic                     wr_n_s;
  logic [6:0]               addr_s;
  logic [7:0]               data_s;
  logic                     rd_act;
  logic                     wr_act;
  logic                     wr_stb;
  logic                     rd_end;
  logic                     wr_control;
  logic                     wr_mask;
  logic                     fast;
  logic                     sync_accept;
  logic [2:0]               limit;
  logic [7:0]               ctl_new;
  logic                     flag_read;
  logic                     rx_reset;
  logic                     tx_reset;
  logic                     err_block;
  logic [MCT_NUM_FLAGS-1:0] flag_src;
  logic [MCT_NUM_FLAGS-1:0] flag_next;
  logic [MCT_NUM_FLAGS-1:0] irq_hit;

  // Only the second synchroniser stage is decoded.
  assign cs_n_s = st_reg.pins_s2.cs_n;
  assign rd_n_s = st_reg.pins_s2.rd_n;
  assign wr_n_s = st_reg.pins_s2.wr_n;
  assign addr_s = st_reg.pins_s2.addr;
  assign data_s = st_reg.pins_s2.data;

  assign rd_act = ~cs_n_s & ~rd_n_s;
  assign wr_act = ~cs_n_s & ~wr_n_s & rd_n_s;

  // A write commits when the strobe ends, using the last sampled address and data.
  assign wr_stb     = st_reg.wr_act_d & ~wr_act;
  assign rd_end     = st_reg.rd_act_d & ~rd_act;
  assign timer_load = wr_stb & (st_reg.acc_addr == MCT_ADDR_TIMER);
  assign wr_control = wr_stb & (st_reg.acc_addr == MCT_ADDR_CONTROL);
  assign wr_mask    = wr_stb & (st_reg.acc_addr == MCT_ADDR_MASK);

  assign fast  = st_reg.control[MCT_CTL_FAST_LOCK];
  assign limit = st_reg.control[MCT_CTL_SYNC_WORD_ERROR_LIMIT_MSB:MCT_CTL_SYNC_WORD_ERROR_LIMIT_LSB];

  assign sync_accept = sync_candidate & (sync_candidate_errors <= limit)
                       & ~st_reg.control[MCT_CTL_RX_PS];
  assign flag_read   = rd_end & (st_reg.acc_addr == MCT_ADDR_FLAGS);
  // Writing receiver powersave resets the receive flags and status.
  assign rx_reset    = wr_control & st_reg.acc_data[MCT_CTL_RX_PS];
  // Writing transmitter powersave marks the transmit buffer empty.
  assign tx_reset    = wr_control & st_reg.acc_data[MCT_CTL_TX_PS];
  assign err_block   = ~st_reg.mask[MCT_MSK_ERR_GATE] & errored_data;

  assign flag_src[MCT_FLG_SYNC]  = sync_accept | sync_lost;
  assign flag_src[MCT_FLG_DEC]   = decode_change;
  assign flag_src[MCT_FLG_IDLE]  = idle_change;
  assign flag_src[MCT_FLG_TX]    = tx_buffer_empty | tx_reset;
  assign flag_src[MCT_FLG_TIMER] = timer_expired;

  // Each flag is one slice; the receive flags share the clear and the error gate.
  for (genvar g = 0; g < MCT_NUM_FLAGS; g++) begin : g_flag
    localparam bit RX_KIND = (g == MCT_FLG_SYNC) || (g == MCT_FLG_DEC)
                             || (g == MCT_FLG_IDLE);
    // read clears flags
    // A new event wins over a clear in the same cycle.
    assign flag_next[g] = (st_reg.flags[g] & ~flag_read & ~(RX_KIND & rx_reset))
                          | flag_src[g];
    assign irq_hit[g]   = st_reg.flags[g] & st_reg.mask[MCT_MSK_SRC_LSB + g]
                          & ~(RX_KIND & err_block);
  end

  mct_sleep_timer #(
    .SECOND_CYCLES (SECOND_CYCLES)
  ) u_timer (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .load         (timer_load),
    .load_seconds (st_reg.acc_data),
    .expired      (timer_expired),
    .powersave    (timer_ps)
  );

  always_comb begin
    st_next = st_reg;
    st_next.pins_s1 = {bus_cs_n, bus_rd_n, bus_wr_n, bus_addr, bus_data_in};
    st_next.pins_s2 = st_reg.pins_s1;
    st_next.wr_act_d = wr_act;
    st_next.rd_act_d = rd_act;
    if (rd_act || wr_act) begin
      st_next.acc_addr = addr_s;
      st_next.acc_data = data_s;
    end

    ctl_new = st_reg.control;
    if (wr_control) begin
      ctl_new = st_reg.acc_data;
    end
    st_next.control = ctl_new;
    if (wr_mask) begin
      st_next.mask = st_reg.acc_data;
    end

    st_next.rx_load = sync_accept;
    if (rx_reset) begin
      st_next.sync_errs = MCT_ERR_RST;
    end
    if (sync_accept) begin
      st_next.sync_errs = sync_candidate_errors;
    end

    st_next.flags = flag_next;
    st_next.irq_n = ~|irq_hit;
    st_next.freeze = ctl_new[MCT_CTL_HOLD] & ~ctl_new[MCT_CTL_FAST_LOCK];

    if (fast) begin
      st_next.bw     = MCT_BW_WIDE;
      st_next.bw_cnt = '0;
    end else begin
      case (st_reg.bw)
        MCT_BW_WIDE: begin
          st_next.bw     = MCT_BW_MEDIUM;
          st_next.bw_cnt = '0;
        end
        MCT_BW_MEDIUM: begin
          if (bit_tick) begin
            if (st_reg.bw_cnt == MED_LAST) begin
              st_next.bw = MCT_BW_NARROW;
            end else begin
              st_next.bw_cnt = st_reg.bw_cnt + CW'(1);
            end
          end
        end
        MCT_BW_NARROW: begin
          st_next.bw = MCT_BW_NARROW;
        end
        default: begin
          st_next.bw = MCT_BW_NARROW;
        end
      endcase
    end

    st_next.ci_d = st_reg.control[MCT_CTL_CI];
    if (st_reg.control[MCT_CTL_CI] && !st_reg.ci_d) begin
      st_next.preamble = 1'b1;
    end else if (st_reg.control[MCT_CTL_TX_PS]) begin
      st_next.preamble = 1'b1;
    end else if (tx_block_start) begin
      st_next.preamble = 1'b0;
    end

    // The data bus is driven only while a flag read is in progress.
    st_next.doe  = rd_act & (addr_s == MCT_ADDR_FLAGS);
    st_next.dout = '0;
    if (rd_act && (addr_s == MCT_ADDR_FLAGS)) begin
      st_next.dout[MCT_FLAG_POS_LSB +: MCT_NUM_FLAGS] = st_reg.flags;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg.pins_s1   <= '1;
      st_reg.pins_s2   <= '1;
      st_reg.wr_act_d  <= 1'b0;
      st_reg.rd_act_d  <= 1'b0;
      st_reg.acc_addr  <= '0;
      st_reg.acc_data  <= '0;
      st_reg.control   <= MCT_CONTROL_RST;
      st_reg.mask      <= MCT_MASK_RST;
      st_reg.flags     <= '0;
      st_reg.sync_errs <= MCT_ERR_RST;
      st_reg.rx_load   <= 1'b0;
      st_reg.bw        <= MCT_BW_NARROW;
      st_reg.bw_cnt    <= '0;
      st_reg.ci_d      <= 1'b0;
      st_reg.preamble  <= 1'b1;
      st_reg.freeze    <= 1'b0;
      st_reg.irq_n     <= 1'b1;
      st_reg.dout      <= '0;
      st_reg.doe       <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_data_out            = st_reg.dout;
  assign bus_data_oe             = st_reg.doe;
  assign interrupt_request_pin_n = st_reg.irq_n;
  assign receiver_powersave      = st_reg.control[MCT_CTL_RX_PS];
  assign transmitter_powersave   = st_reg.control[MCT_CTL_TX_PS];
  assign continuity_indicator    = st_reg.control[MCT_CTL_CI];
  assign fast_peak_detect        = st_reg.control[MCT_CTL_FAST_LOCK];
  assign loop_bandwidth          = st_reg.bw;
  assign phase_freeze            = st_reg.freeze;
  assign preamble_pending        = st_reg.preamble;
  assign rx_load                 = st_reg.rx_load;
  assign sync_error_count        = st_reg.sync_errs;
  assign timer_powersave         = timer_ps;

endmodule

// ### dv/mct_control_monitor.sv
`timescale 1ns/1ps
module mct_control_monitor
  import mct_pkg::*;
#(
  parameter int SECOND_CYCLES = MCT_SECOND_CYCLES,
  parameter int MEDIUM_BITS   = MCT_MEDIUM_BW_BITS
) (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       bus_cs_n,
  input wire logic       bus_wr_n,
  input wire logic [7:0] bus_data_out,
  input wire logic       bus_data_oe,
  input wire logic       sync_candidate,
  input wire logic [2:0] sync_candidate_errors,
  input wire logic       receiver_powersave,
  input wire logic       transmitter_powersave,
  input wire logic       continuity_indicator,
  input wire logic       fast_peak_detect,
  input wire logic [1:0] loop_bandwidth,
  input wire logic       phase_freeze,
  input wire logic       preamble_pending,
  input wire logic       rx_load,
  input wire logic [2:0] sync_error_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Cycles since the bus last showed an active write on the pins.
  logic [3:0] wr_age_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || (!bus_cs_n && !bus_wr_n)) begin
      wr_age_reg <= 4'h0;
    end else if (wr_age_reg != 4'hF) begin
      wr_age_reg <= wr_age_reg + 4'h1;
    end
  end

  property p_hold_ignored;
    fast_peak_detect |-> !phase_freeze;
  endproperty
  a_hold_ignored: assert property (p_hold_ignored)
    else $error("phase frozen during fast lock");
  property p_wide_bw;
    fast_peak_detect && $past(fast_peak_detect) |-> loop_bandwidth == MCT_BW_WIDE;
  endproperty
  a_wide_bw: assert property (p_wide_bw)
    else $error("loop not wide during fast lock");
  property p_medium_bw;
    $fell(fast_peak_detect) |-> ##[0:2] (loop_bandwidth == MCT_BW_MEDIUM);
  endproperty
  a_medium_bw: assert property (p_medium_bw)
    else $error("loop not medium after fast lock");
  property p_sync_load;
    rx_load |-> $past(sync_candidate) && !$past(receiver_powersave)
      && sync_error_count == $past(sync_candidate_errors);
  endproperty
  a_sync_load: assert property (p_sync_load)
    else $error("receive load without matching candidate");
  property p_no_load_saved;
    sync_candidate && receiver_powersave |=> !rx_load;
  endproperty
  a_no_load_saved: assert property (p_no_load_saved)
    else $error("receive load while receiver powersaved");
  property p_write_only;
    $changed({receiver_powersave, transmitter_powersave, continuity_indicator})
      |-> wr_age_reg < 4'h8;
  endproperty
  a_write_only: assert property (p_write_only)
    else $error("control output changed without a write");
  property p_preamble;
    $rose(continuity_indicator) |-> ##[0:1] preamble_pending;
  endproperty
  a_preamble: assert property (p_preamble)
    else $error("no preamble after continuity rise");
  property p_read_low_bits;
    bus_data_oe |-> bus_data_out[2:0] == 3'h0;
  endproperty
  a_read_low_bits: assert property (p_read_low_bits)
    else $error("flag read low bits not zero");
endmodule

bind mct_control_top mct_control_monitor #(
  .SECOND_CYCLES(SECOND_CYCLES), .MEDIUM_BITS(MEDIUM_BITS)
) mct_control_monitor_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_cs_n(bus_cs_n), .bus_wr_n(bus_wr_n),
  .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .sync_candidate(sync_candidate),
  .sync_candidate_errors(sync_candidate_errors), .receiver_powersave(receiver_powersave),
  .transmitter_powersave(transmitter_powersave), .continuity_indicator(continuity_indicator),
  .fast_peak_detect(fast_peak_detect), .loop_bandwidth(loop_bandwidth),
  .phase_freeze(phase_freeze), .preamble_pending(preamble_pending), .rx_load(rx_load),
  .sync_error_count(sync_error_count));

// ### dv/mct_host_model.sv
`timescale 1ns/1ps
module mct_host_model
  import mct_pkg::*;
(
  input  wire logic       sys_clk,
  output logic            bus_cs_n,
  output logic            bus_rd_n,
  output logic            bus_wr_n,
  output logic      [6:0] bus_addr,
  output logic      [7:0] bus_data_in
);
  initial begin
    bus_cs_n = 1'b1;
    bus_rd_n = 1'b1;
    bus_wr_n = 1'b1;
    bus_addr = 7'h00;
    bus_data_in = 8'h00;
  end

  // Strobes stay low and then high for five cycles, above the three the sync stage needs.
  task automatic access(input logic [6:0] a, input logic [7:0] d, input logic rd);
    @(posedge sys_clk);
    bus_cs_n <= 1'b0;
    bus_rd_n <= ~rd;
    bus_wr_n <= rd;
    bus_addr <= a;
    bus_data_in <= d;
    repeat (5) @(posedge sys_clk);
    bus_cs_n <= 1'b1;
    bus_rd_n <= 1'b1;
    bus_wr_n <= 1'b1;
    bus_data_in <= ~d;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic power_up_init();
    access(MCT_ADDR_FLAGS, 8'h00, 1'b1);
    access(MCT_ADDR_CONTROL, 8'h30, 1'b0);
  endtask
endmodule

// ### dv/modem_control_timer_irq_mask_tb.sv
`timescale 1ns/1ps
module modem_control_timer_irq_mask_tb;
  import mct_pkg::*;
  localparam int SEC = 20;
  localparam int MED = 4;
  logic       sys_clk, sys_rst, bit_tick, sync_candidate, tx_block_start, errored_data, oe_d;
  logic [2:0] sync_candidate_errors, tcnt, cnt;
  logic [3:0] ev;
  logic [7:0] v, exp_flags;
  wire        bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe, irq_n, rx_ps, tx_ps, ci, fast;
  wire        freeze, pre, rx_load, tmr_ps;
  wire  [6:0] bus_addr;
  wire  [7:0] bus_data_in, bus_data_out;
  wire  [1:0] bw;
  wire  [2:0] sec_cnt;
  int         n_mismatch, n_tests, seed, i;
  logic [7:0] exp_q[$];

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  mct_control_top #(.SECOND_CYCLES(SEC), .MEDIUM_BITS(MED)) mct_control_top_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n),
    .bus_wr_n(bus_wr_n), .bus_addr(bus_addr), .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .bit_tick(bit_tick),
    .sync_candidate(sync_candidate), .sync_candidate_errors(sync_candidate_errors),
    .sync_lost(ev[3]), .decode_change(ev[2]), .idle_change(ev[1]), .tx_buffer_empty(ev[0]),
    .tx_block_start(tx_block_start), .errored_data(errored_data),
    .interrupt_request_pin_n(irq_n), .receiver_powersave(rx_ps),
    .transmitter_powersave(tx_ps), .continuity_indicator(ci), .fast_peak_detect(fast),
    .loop_bandwidth(bw), .phase_freeze(freeze), .preamble_pending(pre), .rx_load(rx_load),
    .sync_error_count(sec_cnt), .timer_powersave(tmr_ps));
  mct_host_model mct_host_model_i (.sys_clk(sys_clk), .bus_cs_n(bus_cs_n),
    .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_addr(bus_addr), .bus_data_in(bus_data_in));

  task automatic check(input string what, input logic [15:0] e, input logic [15:0] got);
    n_tests++;
    if (got !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    mct_host_model_i.access(a, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] e);
    exp_q.push_back(e);
    mct_host_model_i.access(MCT_ADDR_FLAGS, 8'h00, 1'b1);
  endtask
  task automatic sync_try(input logic [2:0] e, input logic ok);
    @(posedge sys_clk);
    sync_candidate <= 1'b1;
    sync_candidate_errors <= e;
    @(posedge sys_clk);
    sync_candidate <= 1'b0;
    sync_candidate_errors <= ~e;
    if (ok) cnt = e;
    @(negedge sys_clk);
    check("sync load", {ok, cnt}, {rx_load, sec_cnt});
  endtask
  task automatic pulse_ev(input int k);
    @(posedge sys_clk);
    ev <= 4'h1 << k;
    @(posedge sys_clk);
    ev <= 4'h0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    tcnt <= tcnt + 3'h1;
    bit_tick <= (tcnt == 3'h7);
  end

  // Each rising output enable is one flag read; the oldest note is its expectation.
  always @(posedge sys_clk) begin
    oe_d <= bus_data_oe;
    if (bus_data_oe === 1'b1 && oe_d !== 1'b1) begin
      check("flags read", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, bus_data_out);
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    seed = 95;
    sys_rst = 1'b1;
    {bit_tick, sync_candidate, tx_block_start, errored_data, oe_d} = 5'h00;
    {sync_candidate_errors, tcnt, cnt, ev, exp_flags} = 21'h0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    check("reset", {8'hC7, 2'h3}, {rx_ps, tx_ps, ci, fast, freeze, pre, tmr_ps, irq_n, bw});
    exp_q.push_back(8'h00);
    mct_host_model_i.power_up_init();
    rd(8'h10);
    for (i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      wr(MCT_ADDR_CONTROL, v);
      exp_flags[4] = exp_flags[4] | v[4];
      check("control", {v[7], v[6] & ~v[7], v[5:3]}, {fast, freeze, rx_ps, tx_ps, ci});
    end
    rd(exp_flags);
    wr(MCT_ADDR_CONTROL, 8'hC3);
    check("fast lock", {3'b100, MCT_BW_WIDE}, {fast, freeze, rx_ps, bw});
    repeat (16 * 8) @(posedge sys_clk);
    wr(MCT_ADDR_CONTROL, 8'h43);
    check("medium bw", {3'b010, MCT_BW_MEDIUM}, {fast, freeze, rx_ps, bw});
    repeat ((MED + 2) * 8) @(negedge sys_clk);
    check("narrow bw", MCT_BW_NARROW, bw);
    for (i = 0; i < 8; i++) sync_try(i[2:0], i <= 3);
    check("masked pin", 1'b1, irq_n);
    wr(MCT_ADDR_MASK, 8'h80);
    check("sync irq", 1'b0, irq_n);
    @(posedge sys_clk) errored_data <= 1'b1;
    repeat (2) @(negedge sys_clk);
    check("error gated", 1'b1, irq_n);
    wr(MCT_ADDR_MASK, 8'h84);
    check("error passed", 1'b0, irq_n);
    @(posedge sys_clk) errored_data <= 1'b0;
    rd(8'h80);
    check("flags cleared", 1'b1, irq_n);
    wr(MCT_ADDR_MASK, 8'hF8);
    for (i = 0; i < 4; i++) begin
      pulse_ev(i);
      check("event irq", 1'b0, irq_n);
      rd(8'h10 << i);
    end
    wr(MCT_ADDR_TIMER, 8'h02);
    check("timer run", 2'b01, {tmr_ps, irq_n});
    repeat (25) @(negedge sys_clk);
    check("timer early", 1'b1, irq_n);
    repeat (30) @(negedge sys_clk);
    check("timer expiry", 1'b0, irq_n);
    rd(8'h08);
    repeat (100) @(negedge sys_clk);
    check("one shot", 1'b1, irq_n);
    wr(MCT_ADDR_TIMER, 8'h00);
    check("timer off", 1'b1, tmr_ps);
    wr(7'h10, 8'hFF);
    check("unmapped write", 3'b010, {fast, freeze, rx_ps});
    mct_host_model_i.access(MCT_ADDR_MASK, 8'h00, 1'b1);
    wr(MCT_ADDR_CONTROL, 8'h30);
    cnt = 3'h0;
    sync_try(3'h0, 1'b0);
    rd(8'h10);
    wr(MCT_ADDR_CONTROL, 8'h08);
    @(posedge sys_clk) tx_block_start <= 1'b1;
    @(posedge sys_clk) tx_block_start <= 1'b0;
    repeat (2) @(negedge sys_clk);
    check("block sent", 1'b0, pre);
    wr(MCT_ADDR_CONTROL, 8'h00);
    wr(MCT_ADDR_CONTROL, 8'h08);
    check("preamble", 1'b1, pre);
    summarize();
  end
endmodule
